// ---- rtl/dsi_defs.svh ----
// constants of the dac serial load interface
`ifndef DSI_DEFS_SVH
`define DSI_DEFS_SVH

// =====================================================================
// word format
// =====================================================================
`define DSI_WORD_BITS   16
`define DSI_BYTE_BITS   8
`define DSI_WIDE_BITS   16
`define DSI_NARROW_BITS 14
`define DSI_CODE_RESET  16'h0000

// =====================================================================
// host timing, in i_mclk cycles
// =====================================================================
`define DSI_HALF_CYC    2
`define DSI_GAP_CYC     4
`define DSI_CS_SET_CYC  2
`define DSI_CS_HOLD_CYC 2

`endif

// ---- rtl/dsi_pkg.sv ----
// types shared by both ends of the dac serial load interface
package dsi_pkg;
    // host sequencer states
    typedef enum logic [2:0] {
        DSI_IDLE,
        DSI_LOW,
        DSI_HIGH,
        DSI_GAP,
        DSI_STROBE,
        DSI_HOLD
    } dsi_host_state_t;
endpackage : dsi_pkg

// ---- rtl/dsi_link_if.sv ----
// three-wire link between host and converter
`timescale 1ns/10ps
interface dsi_link_if;
    logic cs_n;            // select, active low
    logic sclk;            // serial clock, made by the host
    logic serial_data_in;  // serial data, msb first

    modport host (
        output cs_n,
        output sclk,
        output serial_data_in
    );
    modport device (
        input  cs_n,
        input  sclk,
        input  serial_data_in
    );
endinterface : dsi_link_if

// ---- rtl/dsi_device.sv ----
// converter end: serial shift register and dac holding register
//
// What this block does
// R1: updates arrive only over select, data, clock
// R2: sixteen-bit word, B15 down to B0
// R3: most significant bit sent first
// R4: data sampled on serial clock rising edge
// R5: wide variant keeps final sixteen bits only
// R6: select rising edge loads holding register
// R7: host holds clock still during select rise
// R8: host may send two bytes per frame
// R9: narrow variant keeps last fourteen bits
// R10: shifting only while select low
// R11: surplus leading bits are ignored
`timescale 1ns/10ps
`include "dsi_defs.svh"

module dsi_device
    import dsi_pkg::*;
#(
    parameter int WORD_BITS = `DSI_WORD_BITS,
    parameter int DAC_BITS  = `DSI_WIDE_BITS
) (
    // user side clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_arst_n,
    // link from the host
    dsi_link_if.device               link,
    // converter side
    output logic [DAC_BITS-1:0]      o_dac_code,
    output logic                     o_load,
    output logic                     o_frame_busy,
    output logic [WORD_BITS-1:0]     o_last_word
);

    // =================================================================
    // overview
    // =================================================================
    // two clock domains meet here: the link clock, made by the host,
    // drives only the shift register, and i_mclk drives the rest
    // the link clock need not run between frames; nothing in the
    // link domain waits for a later edge, so a stopped clock loses
    // no data
    // the only signal that enters the user domain as a level is
    // select, and it passes two flip-flops first; the word is read
    // as a whole while it is frozen, never bit by bit
    // the converter itself is outside this block: o_dac_code is the
    // holding register that would drive it, o_load marks each update
    // reset clears both domains together; the host parks the link
    // clock low while reset is held

    // =================================================================
    // link domain: serial shift register
    // =================================================================
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] shift_next;
    logic [WORD_BITS-1:0] shift_in;

    // each bit takes its lower neighbour and bit 0 takes the data
    // line, so the msb entered first walks up to the top
    for (genvar b = 0; b < WORD_BITS; b++) begin : g_shift
        if (b == 0) begin : g_first
            assign shift_in[b] = link.serial_data_in;          // see R3
        end else begin : g_rest
            // the top bit of the old word falls off here, so
            // surplus leading bits simply drop out
            assign shift_in[b] = shift_reg[b-1];               // see R11
        end
    end

    // shift one bit in while select is low; with select high the
    // register is frozen, so it is quasi-static when it is read
    always_comb begin
        shift_next = shift_reg;
        if (!link.cs_n) begin                                  // see R10
            shift_next = shift_in;                             // see R5
        end
    end

    // registered on the rising edge of the link clock; reset is
    // released while the host parks that clock low, so no edge
    // meets the release
    always_ff @(posedge link.sclk or negedge i_arst_n) begin   // see R4
        if (!i_arst_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;                           // see R1
        end
    end

    // =================================================================
    // user domain: select synchroniser
    // =================================================================
    // the select line comes from the host's clock domain, so it passes
    // two flip-flops before the edge detector looks at it
    // the word crosses without a synchroniser of its own: it is read
    // only after the synchronised select has risen, and by then the
    // shift register cannot move, since it shifts only while select
    // is low and the host keeps the link clock still around the rise
    // select must therefore stay high for at least three user cycles,
    // or the copy may catch the first bits of the next frame
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic cs_meta_next;
    logic cs_sync_next;
    logic cs_prev_next;
    logic cs_rise;

    // next values of the synchroniser chain
    always_comb begin
        cs_meta_next = link.cs_n;
        cs_sync_next = cs_meta_reg;
        cs_prev_next = cs_sync_reg;
    end

    // select idles high, so the chain resets high and no false
    // rising edge appears after reset
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= cs_meta_next;
            cs_sync_reg <= cs_sync_next;
            cs_prev_reg <= cs_prev_next;
        end
    end

    // rising edge of the synchronised select strobes the transfer;
    // it stands for exactly one user cycle, so each rise of select
    // gives one copy and one load pulse
    assign cs_rise = cs_sync_reg & ~cs_prev_reg;               // see R6

    // =================================================================
    // user domain: dac holding register
    // =================================================================
    // the shift register is read only after select has stood high for
    // three user cycles; the host keeps the clock still then, so the
    // word cannot change while it is copied
    // the narrow variant takes the last fourteen bits entered and
    // drops the two leading ones; a host that sends the code left
    // justified will see it shifted up by two, its top two bits lost
    logic [DAC_BITS-1:0]  code_reg;
    logic [DAC_BITS-1:0]  code_next;
    logic                 load_reg;
    logic                 load_next;

    // copy on the strobe, hold otherwise
    always_comb begin
        code_next = code_reg;                                  // see R10
        load_next = 1'b0;
        if (cs_rise) begin                                     // see R7
            // the low dac_bits of the word are the last bits entered;
            // the narrow variant drops the two leading bits  // see R9
            code_next = shift_reg[DAC_BITS-1:0];               // see R5
            load_next = 1'b1;                                  // see R6
        end
    end

    // holding register and load strobe
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            code_reg <= DAC_BITS'(`DSI_CODE_RESET);
            load_reg <= 1'b0;
        end else begin
            code_reg <= code_next;
            load_reg <= load_next;
        end
    end

    // =================================================================
    // user domain: last word and frame status
    // =================================================================
    // the full word is kept for the user even in the narrow variant,
    // so the two dropped leading bits can still be inspected
    logic [WORD_BITS-1:0] word_reg;
    logic [WORD_BITS-1:0] word_next;
    logic                 busy_reg;
    logic                 busy_next;

    // word copied on the same strobe as the code; busy follows the
    // synchronised select, so it lags the pin by three user cycles
    always_comb begin
        word_next = word_reg;
        busy_next = ~cs_sync_reg;
        if (cs_rise) begin
            word_next = shift_reg;                             // see R2
        end
    end

    // status flip-flops; idle and empty after reset
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            busy_reg <= busy_next;
        end
    end

    // =================================================================
    // outputs
    // =================================================================
    // all come straight from flip-flops in the user domain, so a
    // user may sample them on any i_mclk edge; o_dac_code and
    // o_load change on the same edge, and o_last_word keeps the
    // full word even where the converter takes fewer bits
    assign o_dac_code   = code_reg;
    assign o_load       = load_reg;      // one cycle per transfer
    assign o_frame_busy = busy_reg;      // select seen low
    assign o_last_word  = word_reg;      // full word, surplus dropped

endmodule : dsi_device

// ---- rtl/dsi_host.sv ----
// host end: serialises a word onto the three-wire link
`timescale 1ns/10ps
`include "dsi_defs.svh"

module dsi_host
    import dsi_pkg::*;
#(
    parameter int WORD_BITS = `DSI_WORD_BITS,
    parameter int BYTE_BITS = `DSI_BYTE_BITS,
    parameter int HALF_CYC  = `DSI_HALF_CYC,
    parameter int GAP_CYC   = `DSI_GAP_CYC,
    parameter int SET_CYC   = `DSI_CS_SET_CYC,
    parameter int HOLD_CYC  = `DSI_CS_HOLD_CYC
) (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_arst_n,
    // user request
    input  wire logic                 i_start,
    input  wire logic [WORD_BITS-1:0] i_word,
    input  wire logic                 i_byte_mode,
    // user status
    output logic                      o_ready,
    output logic                      o_done,
    // link to the converter
    dsi_link_if.host                  link
);

    // =================================================================
    // sequencer
    // =================================================================
    dsi_host_state_t      state_reg, state_next;
    logic [WORD_BITS-1:0] word_reg, word_next;
    logic [7:0]           bit_reg, bit_next;
    logic [7:0]           tmr_reg, tmr_next;
    logic                 bytes_reg, bytes_next;
    logic                 cs_n_reg, cs_n_next;
    logic                 sclk_reg, sclk_next;
    logic                 sdi_reg, sdi_next;
    logic                 done_reg, done_next;

    // next state: data changes on the falling edge it makes, so the
    // converter samples a settled bit on the rising one
    always_comb begin
        state_next = state_reg;
        word_next  = word_reg;
        bit_next   = bit_reg;
        tmr_next   = tmr_reg;
        bytes_next = bytes_reg;
        cs_n_next  = cs_n_reg;
        sclk_next  = sclk_reg;
        sdi_next   = sdi_reg;
        done_next  = 1'b0;
        if (tmr_reg != 8'h00) begin
            tmr_next = tmr_reg - 8'h01;
        end
        unique case (state_reg)
            DSI_IDLE: begin
                if (i_start) begin                             // see R1
                    word_next  = i_word;
                    bytes_next = i_byte_mode;
                    bit_next   = 8'(WORD_BITS - 1);
                    cs_n_next  = 1'b0;
                    sdi_next   = i_word[WORD_BITS-1];          // see R3
                    tmr_next   = 8'(SET_CYC - 1);
                    state_next = DSI_LOW;
                end
            end
            DSI_LOW, DSI_GAP: begin
                if (tmr_reg == 8'h00) begin
                    sclk_next  = 1'b1;                         // see R4
                    tmr_next   = 8'(HALF_CYC - 1);
                    state_next = DSI_HIGH;
                end
            end
            DSI_HIGH: begin
                if (tmr_reg == 8'h00) begin
                    sclk_next = 1'b0;
                    if (bit_reg == 8'h00) begin
                        // clock parks low before select rises  // see R7
                        tmr_next   = 8'(SET_CYC - 1);
                        state_next = DSI_STROBE;
                    end else begin
                        bit_next  = bit_reg - 8'h01;
                        word_next = word_reg << 1;
                        sdi_next  = word_reg[WORD_BITS-2];     // see R2
                        tmr_next  = 8'(HALF_CYC - 1);
                        state_next = DSI_LOW;
                        if (bytes_reg && bit_reg == 8'(BYTE_BITS)) begin
                            // pause between the two bytes    // see R8
                            tmr_next   = 8'(GAP_CYC - 1);
                            state_next = DSI_GAP;
                        end
                    end
                end
            end
            DSI_STROBE: begin
                if (tmr_reg == 8'h00) begin
                    cs_n_next  = 1'b1;                         // see R7
                    tmr_next   = 8'(HOLD_CYC - 1);
                    state_next = DSI_HOLD;
                end
            end
            DSI_HOLD: begin
                if (tmr_reg == 8'h00) begin
                    done_next  = 1'b1;
                    state_next = DSI_IDLE;
                end
            end
            default: begin
                state_next = DSI_IDLE;
            end
        endcase
    end

    // registers of the sequencer; link idles with select high
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= DSI_IDLE;
            word_reg  <= '0;
            bit_reg   <= 8'h00;
            tmr_reg   <= 8'h00;
            bytes_reg <= 1'b0;
            cs_n_reg  <= 1'b1;
            sclk_reg  <= 1'b0;
            sdi_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            word_reg  <= word_next;
            bit_reg   <= bit_next;
            tmr_reg   <= tmr_next;
            bytes_reg <= bytes_next;
            cs_n_reg  <= cs_n_next;
            sclk_reg  <= sclk_next;
            sdi_reg   <= sdi_next;
            done_reg  <= done_next;
        end
    end

    // =================================================================
    // outputs
    // =================================================================
    assign link.cs_n           = cs_n_reg;
    assign link.sclk           = sclk_reg;
    assign link.serial_data_in = sdi_reg;
    assign o_ready             = (state_reg == DSI_IDLE);
    assign o_done              = done_reg;

endmodule : dsi_host

// ---- verification/dsi_link_sva.sv ----
// checker for the three-wire link between host and converter
`timescale 1ns/10ps
module dsi_link_sva (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    // link signals
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        serial_data_in,
    // status of both ends
    input  wire logic        o_load,
    input  wire logic [15:0] o_dac_code,
    input  wire logic        o_frame_busy,
    input  wire logic        o_ready,
    input  wire logic        o_done
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    logic [4:0] rise_cnt_reg;
    logic [4:0] rise_cnt_next;
    logic       sclk_reg;

    // =========================================================
    // clock rises seen inside the current frame
    // =========================================================
    always_comb begin
        rise_cnt_next = cs_n ? 5'h00 : rise_cnt_reg + {4'h0, sclk & ~sclk_reg};
    end
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rise_cnt_reg <= 5'h00;
            sclk_reg     <= 1'b0;
        end else begin
            rise_cnt_reg <= rise_cnt_next;
            sclk_reg     <= sclk;
        end
    end

    // =========================================================
    // link and load properties
    // =========================================================
    word_len_a: assert property ($rose(cs_n) |-> rise_cnt_reg == 5'h10)
        else $error("frame did not carry sixteen clock rises");
    frame_open_a: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
        else $error("clock rose too soon after select fell");
    data_hold_a: assert property (sclk |-> $stable(serial_data_in))
        else $error("data moved while clock high");
    strobe_still_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
        else $error("clock moved around the select rise");
    load_delay_a: assert property ($rose(cs_n) |-> ##[2:5] o_load)
        else $error("no load after select rise");
    load_cause_a: assert property (o_load |-> $past(cs_n, 3) && !$past(o_load))
        else $error("load without select rise");
    code_hold_a: assert property (!$stable(o_dac_code) |-> o_load)
        else $error("holding register changed without load");
    busy_track_a: assert property ($fell(cs_n) |-> ##[2:4] o_frame_busy)
        else $error("busy did not follow select");
    busy_clear_a: assert property ($rose(cs_n) |-> ##[2:4] !o_frame_busy)
        else $error("busy did not clear after select rose");
    host_idle_a: assert property (o_ready || o_done |-> cs_n)
        else $error("select low while host idle");
    cover property (o_load);
    cover property ($rose(cs_n));
    cover property (o_done);
endmodule : dsi_link_sva

// ---- verification/test_dac_serial_load_interface.sv ----
// self-checking bench for both ends of the dac serial load interface
`timescale 1ns/10ps
module test_dac_serial_load_interface;
    import dsi_pkg::*;
    logic        i_mclk;
    logic        i_arst_n;
    logic        i_start;
    logic [15:0] i_word;
    logic        i_byte_mode;
    logic        ready, done, load, busy;
    logic [15:0] code, last, rcode, exp_w, mon_w;
    logic [13:0] ncode;
    logic [31:0] rnd;
    int          n_mismatch, samples_checked;
    logic [15:0] corner [4] = '{16'hffff, 16'h0000, 16'h8001, 16'h7ffe};

    dsi_link_if link ();
    dsi_link_if link_b ();
    dsi_host u_dsi_host (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_start(i_start),
        .i_word(i_word), .i_byte_mode(i_byte_mode), .o_ready(ready), .o_done(done), .link(link));
    dsi_device u_dsi_device (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link),
        .o_dac_code(code), .o_load(load), .o_frame_busy(busy), .o_last_word(last));
    dsi_device #(.DAC_BITS(14)) u_dsi_device_narrow (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .link(link), .o_dac_code(ncode), .o_load(), .o_frame_busy(), .o_last_word());
    dsi_device u_dsi_device_rogue (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link_b),
        .o_dac_code(rcode), .o_load(), .o_frame_busy(), .o_last_word());
    dsi_link_sva u_dsi_link_sva (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .serial_data_in(link.serial_data_in), .o_load(load),
        .o_dac_code(code), .o_frame_busy(busy), .o_ready(ready), .o_done(done));

    // =========================================================
    // helpers
    // =========================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one host frame, then compare both converters once the load lands
    task automatic send(input logic [15:0] w, input logic bm);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        @(posedge i_mclk);
        exp_w = w;
        i_start <= 1'b1;
        i_word <= w;
        i_byte_mode <= bm;
        @(posedge i_mclk);
        i_start <= 1'b0;
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
        end while (load !== 1'b1 && n < 300);
        chk("dac_code", w, code);
        chk("last_word", w, last);
        chk("narrow_code", {2'h0, w[13:0]}, {2'h0, ncode});
    endtask : send

    // bench-made link frame at a 15 ns clock, select held at sel_n
    task automatic shift_b(input logic [19:0] bits, input int n, input logic sel_n);
        link_b.cs_n = sel_n;
        for (int i = n - 1; i >= 0; i--) begin
            link_b.serial_data_in = bits[i];
            #7.5 link_b.sclk = 1'b1;
            #7.5 link_b.sclk = 1'b0;
        end
        link_b.serial_data_in = ~link_b.serial_data_in;
        #7.5 link_b.cs_n = 1'b1;
        repeat (8) @(posedge i_mclk);
        #1;
    endtask : shift_b

    task automatic report_and_stop();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // reassembles each frame seen on the wire
    always @(posedge link.sclk) if (!link.cs_n) mon_w <= {mon_w[14:0], link.serial_data_in};
    always @(posedge link.cs_n) if (i_arst_n === 1'b1) chk("wire_word", exp_w, mon_w);

    // =========================================================
    // clock, watchdog and main sequence
    // =========================================================
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        rnd = 32'hc3e8df10;
        i_arst_n = 1'b0;
        i_start = 1'b0;
        i_word = 16'h0000;
        i_byte_mode = 1'b0;
        exp_w = 16'h0000;
        mon_w = 16'h0000;
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.serial_data_in = 1'b0;
        repeat (16) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        chk("reset_code", 16'h0000, code);
        foreach (corner[i]) send(corner[i], i[0]);
        repeat (24) begin
            rnd = lfsr(rnd);
            send(rnd[15:0], rnd[16]);
        end
        shift_b({4'ha, 16'h5a3c}, 20, 1'b0);
        chk("surplus_bits", 16'h5a3c, rcode);
        rnd = lfsr(rnd);
        shift_b({4'h0, rnd[15:0]}, 16, 1'b1);
        chk("select_high", 16'h5a3c, rcode);
        shift_b({12'h000, 8'hc5}, 8, 1'b0);
        chk("short_frame", 16'h3cc5, rcode);
        shift_b({4'h0, rnd[15:0]}, 16, 1'b0);
        chk("plain_frame", rnd[15:0], rcode);
        report_and_stop();
    end
endmodule : test_dac_serial_load_interface
